/* ccr_clock_ratio_ctrl.sv */
// cluster clock ratio control: prescaler, domain dividers, hub power-up
// Functional notes
// - prescaler divides clock by divisor plus one
// - divisor accepted only with update enable set
// - prescaler output feeds every clock domain
// - readback field shows active prescale ratio
// - each core domain divides further, 1:1 to 1:8
// - hub domain limited to 1:1 or 1:2
// - one local ratio register per domain
// - request bit starts coordinated ratio change
// - hardware clears request bit when done
// - busy bit high while change runs
// - settle delay field, default 80 clocks
// - hub powered whenever any core powered
// - debug write powers non-operational hub until cleared by debug write of zero
// - hub power-up write of one ignored when operational
// - unmapped reads zero, writes dropped silently
`timescale 1ns/1ps
module ccr_clock_ratio_ctrl #(
   parameter int NUM_CORES = 2
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire ccr_pkg::ccr_req_type reg_req,
   output ccr_pkg::ccr_rsp_type reg_rsp,
   input wire logic [NUM_CORES-1:0] core_powered_up,
   input wire logic hub_operational,
   output logic hub_power_req,
   output logic prescale_clk_en,
   output logic [NUM_CORES:0] domain_clk_en
);
   import ccr_pkg::*;

   // domain 0 is the coherence hub, domains 1..NUM_CORES are cores
   localparam int NUM_DOM = NUM_CORES + 1;

   if (NUM_CORES < 1 || NUM_CORES > 64) begin : g_bad_cores
      $error("NUM_CORES out of range");
   end

   // local ratio register decode: index of domain, or NUM_DOM if none
   function automatic int local_index(input logic [15:0] addr);
      int idx;
      idx = NUM_DOM;
      if (addr >= OFS_LOCAL_BASE &&
          addr[LOCAL_STRIDE_LSB-1:0] == OFS_LOCAL_RATIO[7:0]) begin
         idx = int'(addr[15:LOCAL_STRIDE_LSB]) -
               int'(OFS_LOCAL_BASE[15:LOCAL_STRIDE_LSB]);
         if (idx >= NUM_DOM) begin
            idx = NUM_DOM;
         end
      end
      return idx;
   endfunction

   ccr_state_type state;
   ccr_state_type next_state;
   logic [7:0] presc_div;
   logic [7:0] next_presc_div;
   logic presc_en;
   logic next_presc_en;
   logic [7:0] presc_cnt;
   logic [7:0] next_presc_cnt;
   logic presc_tick;
   logic chg_req;
   logic next_chg_req;
   logic [9:0] settle_dly;
   logic [9:0] next_settle_dly;
   logic [9:0] settle_cnt;
   logic [9:0] next_settle_cnt;
   logic hub_standalone;
   logic next_hub_standalone;
   logic [RATIO_W-1:0] dom_pend [NUM_DOM];
   logic [RATIO_W-1:0] next_dom_pend [NUM_DOM];
   logic [RATIO_W-1:0] dom_act [NUM_DOM];
   logic [RATIO_W-1:0] next_dom_act [NUM_DOM];
   logic [RATIO_W-1:0] dom_cnt [NUM_DOM];
   logic [RATIO_W-1:0] next_dom_cnt [NUM_DOM];
   logic [NUM_DOM-1:0] applied;
   logic [NUM_DOM-1:0] next_applied;
   logic [NUM_DOM-1:0] dom_edge;
   logic [NUM_DOM-1:0] next_dom_en;
   logic next_presc_clk_en;
   ccr_rsp_type next_rsp;
   int wr_idx;
   int rd_idx;

   assign wr_idx = local_index(reg_req.addr);
   assign rd_idx = wr_idx;

   // prescaler tick; >= covers a divisor lowered mid-count
   assign presc_tick = (presc_cnt >= presc_div);

   // prescaler, control registers and sequencer
   always_comb begin
      next_presc_div = presc_div;
      next_presc_en = presc_en;
      next_presc_cnt = presc_tick ? 8'h00 : presc_cnt + 8'h01;
      next_presc_clk_en = presc_tick;
      next_chg_req = chg_req;
      next_settle_dly = settle_dly;
      next_settle_cnt = settle_cnt;
      next_hub_standalone = hub_standalone;
      next_state = state;
      if (reg_req.wr) begin
         unique case (reg_req.addr)
            OFS_PRESCALE: begin
               next_presc_en = reg_req.wdata[PRESC_EN_BIT];
               if (reg_req.wdata[PRESC_EN_BIT]) begin
                  next_presc_div =
                     reg_req.wdata[PRESC_DIV_LSB +: PRESC_DIV_W];
               end
            end
            OFS_GLOBAL_CC: begin
               next_settle_dly =
                  reg_req.wdata[SETTLE_DLY_LSB +: SETTLE_DLY_W];
               if (state == ST_IDLE && !chg_req &&
                   reg_req.wdata[CC_REQ_BIT]) begin
                  next_chg_req = 1'b1;
               end
            end
            OFS_HUB_PWRUP: begin
               // held request, set only from a non-operational hub, cleared by a debug write of zero
               if (reg_req.debug && !hub_operational) begin
                  next_hub_standalone = reg_req.wdata[HUB_PWR_BIT];
               end else if (reg_req.debug &&
                            !reg_req.wdata[HUB_PWR_BIT]) begin
                  next_hub_standalone = 1'b0;
               end
            end
            default: begin
            end
         endcase
      end
      unique case (state)
         ST_IDLE: begin
            if (chg_req) begin
               next_state = ST_SETTLE;
               next_settle_cnt = settle_dly;
            end
         end
         ST_SETTLE: begin
            if (settle_cnt == 10'h000) begin
               next_state = ST_APPLY;
            end else begin
               next_settle_cnt = settle_cnt - 10'h001;
            end
         end
         ST_APPLY: begin
            if (&applied) begin
               next_state = ST_IDLE;
               next_chg_req = 1'b0;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         state <= ST_IDLE;
         presc_div <= PRESC_DIV_RST;
         presc_en <= 1'b0;
         presc_cnt <= 8'h00;
         prescale_clk_en <= 1'b0;
         chg_req <= 1'b0;
         settle_dly <= SETTLE_DLY_RST;
         settle_cnt <= 10'h000;
         hub_standalone <= 1'b0;
      end else begin
         state <= next_state;
         presc_div <= next_presc_div;
         presc_en <= next_presc_en;
         presc_cnt <= next_presc_cnt;
         prescale_clk_en <= next_presc_clk_en;
         chg_req <= next_chg_req;
         settle_dly <= next_settle_dly;
         settle_cnt <= next_settle_cnt;
         hub_standalone <= next_hub_standalone;
      end
   end

   // per-domain dividers, all stepped by the prescaler tick
   generate
      for (genvar i = 0; i < NUM_DOM; i++) begin : g_dom
         assign dom_edge[i] = presc_tick && (dom_cnt[i] >= dom_act[i]);
         always_comb begin
            next_dom_pend[i] = dom_pend[i];
            next_dom_act[i] = dom_act[i];
            next_applied[i] = applied[i];
            next_dom_cnt[i] = dom_cnt[i];
            next_dom_en[i] = dom_edge[i];
            if (presc_tick) begin
               next_dom_cnt[i] = dom_edge[i] ? 3'h0 : dom_cnt[i] + 3'h1;
            end
            if (reg_req.wr && wr_idx == i) begin
               next_dom_pend[i] = reg_req.wdata[RATIO_W-1:0];
               if (i == 0 && reg_req.wdata[RATIO_W-1:0] > HUB_RATIO_MAX) begin
                  next_dom_pend[i] = HUB_RATIO_MAX;
               end
            end
            if (state != ST_APPLY) begin
               next_applied[i] = 1'b0;
            end else if (!applied[i] && dom_edge[i]) begin
               next_dom_act[i] = dom_pend[i];
               next_applied[i] = 1'b1;
            end
         end
         always_ff @(posedge clk_sys or posedge sys_rst) begin
            if (sys_rst) begin
               dom_pend[i] <= RATIO_RST;
               dom_act[i] <= RATIO_RST;
               dom_cnt[i] <= 3'h0;
               applied[i] <= 1'b0;
               domain_clk_en[i] <= 1'b0;
            end else begin
               dom_pend[i] <= next_dom_pend[i];
               dom_act[i] <= next_dom_act[i];
               dom_cnt[i] <= next_dom_cnt[i];
               applied[i] <= next_applied[i];
               domain_clk_en[i] <= next_dom_en[i];
            end
         end
      end
   endgenerate

   assign hub_power_req = (|core_powered_up) || hub_standalone;

   // read answer, one cycle after the request
   always_comb begin
      next_rsp.valid = reg_req.rd;
      next_rsp.data = RD_ZERO;
      if (reg_req.rd) begin
         unique case (reg_req.addr)
            OFS_PRESCALE: begin
               next_rsp.data[PRESC_DIV_LSB +: PRESC_DIV_W] = presc_div;
               next_rsp.data[PRESC_EN_BIT] = presc_en;
               next_rsp.data[PRESC_RB_LSB +: PRESC_DIV_W] = presc_div;
            end
            OFS_GLOBAL_CC: begin
               next_rsp.data[CC_REQ_BIT] = chg_req;
               next_rsp.data[CC_BUSY_BIT] = (state != ST_IDLE);
               next_rsp.data[SETTLE_DLY_LSB +: SETTLE_DLY_W] = settle_dly;
            end
            OFS_HUB_PWRUP: begin
               next_rsp.data[HUB_PWR_BIT] = hub_standalone;
            end
            default: begin
               if (rd_idx < NUM_DOM) begin
                  next_rsp.data[RATIO_W-1:0] = dom_pend[rd_idx];
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rsp <= '0;
      end else begin
         reg_rsp <= next_rsp;
      end
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);

   sequence s_start;
      state == ST_IDLE && chg_req;
   endsequence
   sequence s_settle_end;
      state == ST_SETTLE && settle_cnt == 10'h000;
   endsequence
   sequence s_finish;
      state == ST_APPLY && (&applied);
   endsequence

   presc_wrap_a: assert property (
      presc_tick |=> presc_cnt == 8'h00 && prescale_clk_en)
      else $error("prescaler did not wrap on tick");
   presc_gate_a: assert property (
      reg_req.wr && reg_req.addr == OFS_PRESCALE &&
      !reg_req.wdata[PRESC_EN_BIT] |=> $stable(presc_div))
      else $error("divisor changed without update enable");
   presc_readback_a: assert property (
      reg_req.rd && reg_req.addr == OFS_PRESCALE |=>
      reg_rsp.valid &&
      reg_rsp.data[PRESC_RB_LSB +: PRESC_DIV_W] == $past(presc_div))
      else $error("prescale readback wrong");
   hub_ratio_a: assert property (dom_act[0] <= HUB_RATIO_MAX)
      else $error("hub ratio beyond 1:2");
   change_start_a: assert property (
      s_start |=> state == ST_SETTLE && settle_cnt == $past(settle_dly))
      else $error("change request did not start settle");
   settle_end_a: assert property (
      s_settle_end |=> state == ST_APPLY)
      else $error("settle delay did not end");
   change_done_a: assert property (
      s_finish |=> state == ST_IDLE && !chg_req)
      else $error("request bit not cleared at completion");
   busy_flag_a: assert property (
      reg_req.rd && reg_req.addr == OFS_GLOBAL_CC |=>
      reg_rsp.data[CC_BUSY_BIT] == ($past(state) != ST_IDLE))
      else $error("busy bit wrong");
   hub_power_a: assert property (
      (|core_powered_up) |-> hub_power_req)
      else $error("hub not powered with core up");
   hub_ignore_a: assert property (
      reg_req.wr && reg_req.addr == OFS_HUB_PWRUP && hub_operational &&
      reg_req.wdata[HUB_PWR_BIT] |=> $stable(hub_standalone))
      else $error("hub power-up write not ignored");
   unmapped_a: assert property (
      reg_req.rd && reg_req.addr < OFS_LOCAL_BASE &&
      reg_req.addr != OFS_PRESCALE && reg_req.addr != OFS_GLOBAL_CC &&
      reg_req.addr != OFS_HUB_PWRUP |=> reg_rsp.data == RD_ZERO)
      else $error("unmapped read not zero");
endmodule

/* ccr_pkg.sv */
// constants and types for the cluster clock ratio controller
package ccr_pkg;
   // register offsets
   localparam logic [15:0] OFS_GLOBAL_CC = 16'h0028;
   localparam logic [15:0] OFS_HUB_PWRUP = 16'h0030;
   localparam logic [15:0] OFS_PRESCALE = 16'h0048;
   localparam logic [15:0] OFS_LOCAL_BASE = 16'h1000;
   localparam logic [15:0] OFS_LOCAL_RATIO = 16'h0018;
   localparam int LOCAL_STRIDE_LSB = 8;
   // master prescale control fields
   localparam int PRESC_DIV_LSB = 0;
   localparam int PRESC_DIV_W = 8;
   localparam int PRESC_EN_BIT = 8;
   localparam int PRESC_RB_LSB = 16;
   localparam logic [7:0] PRESC_DIV_RST = 8'h03;
   // global clock change control fields
   localparam int CC_REQ_BIT = 8;
   localparam int CC_BUSY_BIT = 10;
   localparam int SETTLE_DLY_LSB = 20;
   localparam int SETTLE_DLY_W = 10;
   localparam logic [9:0] SETTLE_DLY_RST = 10'h050;
   // local ratio field
   localparam int RATIO_W = 3;
   localparam logic [2:0] RATIO_RST = 3'h0;
   localparam logic [2:0] HUB_RATIO_MAX = 3'h1;
   localparam int HUB_PWR_BIT = 0;
   localparam logic [63:0] RD_ZERO = 64'h0000_0000_0000_0000;

   typedef struct packed {
      logic wr;
      logic rd;
      logic debug;
      logic [15:0] addr;
      logic [63:0] wdata;
   } ccr_req_type;

   typedef struct packed {
      logic valid;
      logic [63:0] data;
   } ccr_rsp_type;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SETTLE = 3'b010,
      ST_APPLY = 3'b100
   } ccr_state_type;
endpackage

/* tb_top.sv */
// self-checking testbench for the cluster clock ratio controller
`timescale 1ns/1ps
module tb_top;
   import ccr_pkg::*;
   localparam int NC = 2;
   logic clk_sys;
   logic sys_rst;
   ccr_req_type req;
   ccr_rsp_type rsp;
   logic [NC-1:0] core_up;
   logic hub_op;
   logic hub_req;
   logic psc_en;
   logic [NC:0] dom_en;
   int n_fail = 0;
   int cmp_count = 0;
   int cyc = 0;
   int per;
   int t0;
   int n;
   logic seen_busy;
   logic [63:0] rd;

   ccr_clock_ratio_ctrl #(.NUM_CORES(NC)) dut (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .reg_req(req),
      .reg_rsp(rsp),
      .core_powered_up(core_up),
      .hub_operational(hub_op),
      .hub_power_req(hub_req),
      .prescale_clk_en(psc_en),
      .domain_clk_en(dom_en)
   );

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
   end

   task automatic tally_and_finish;
      $display("comparisons=%0d mismatches=%0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk_word(input logic [63:0] got, input logic [63:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_num(input int got, input int exp);
      cmp_count++;
      if (got != exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [63:0] d,
                     input logic dbg);
      @(negedge clk_sys);
      req.wr = 1'b1;
      req.addr = a;
      req.wdata = d;
      req.debug = dbg;
      @(negedge clk_sys);
      req.wr = 1'b0;
      req.debug = 1'b0;
   endtask

   task automatic rd_reg(input logic [15:0] a, output logic [63:0] d);
      @(negedge clk_sys);
      req.rd = 1'b1;
      req.addr = a;
      @(negedge clk_sys);
      req.rd = 1'b0;
      chk_bit(rsp.valid, 1'b1);
      d = rsp.data;
   endtask

   function automatic logic sig(input int s);
      return (s > NC) ? psc_en : dom_en[s];
   endfunction

   // first two passes skip any transient after a ratio change
   task automatic period(input int sel, output int p);
      for (int k = 0; k < 3; k++) begin
         p = 0;
         do begin
            @(negedge clk_sys);
            p++;
         end while (sig(sel) !== 1'b1 && p < 4000);
      end
   endtask

   initial begin
      #500000;
      n_fail++;
      tally_and_finish;
   end

   initial begin
      req = '0;
      sys_rst = 1'b1;
      core_up = '0;
      hub_op = 1'b0;
      repeat (5) @(negedge clk_sys);
      sys_rst = 1'b0;
      rd_reg(OFS_PRESCALE, rd);
      chk_word(rd, 64'h0000_0000_0003_0003);
      rd_reg(OFS_GLOBAL_CC, rd);
      chk_word(rd, 64'h0000_0000_0500_0000);
      period(NC + 1, per);
      chk_num(per, 4);
      period(1, per);
      chk_num(per, 4);
      wr(OFS_PRESCALE, 64'h0000_0000_0000_0001, 1'b0);
      period(NC + 1, per);
      chk_num(per, 4);
      wr(OFS_PRESCALE, 64'h0000_0000_0000_0101, 1'b0);
      period(NC + 1, per);
      chk_num(per, 2);
      rd_reg(OFS_PRESCALE, rd);
      chk_word(rd, 64'h0000_0000_0001_0101);
      wr(OFS_PRESCALE, 64'h0000_0000_0000_0100, 1'b0);
      period(NC + 1, per);
      chk_num(per, 1);
      // unmapped locations
      wr(16'h0060, 64'hFFFF_FFFF_FFFF_FFFF, 1'b0);
      rd_reg(16'h0060, rd);
      chk_word(rd, 64'h0000_0000_0000_0000);
      rd_reg(16'h0008, rd);
      chk_word(rd, 64'h0000_0000_0000_0000);
      // pending domain ratios
      wr(16'h1018, 64'h0000_0000_0000_0007, 1'b0);
      rd_reg(16'h1018, rd);
      chk_word(rd, 64'h0000_0000_0000_0001);
      wr(16'h1118, 64'h0000_0000_0000_0003, 1'b0);
      rd_reg(16'h1118, rd);
      chk_word(rd, 64'h0000_0000_0000_0003);
      rd_reg(16'h1018, rd);
      chk_word(rd, 64'h0000_0000_0000_0001);
      period(1, per);
      chk_num(per, 1);
      // coordinated change with a settle delay of 5
      t0 = cyc;
      wr(OFS_GLOBAL_CC, 64'h0000_0000_0050_0100, 1'b0);
      rd_reg(OFS_GLOBAL_CC, rd);
      chk_bit(rd[CC_REQ_BIT], 1'b1);
      seen_busy = 1'b0;
      n = 0;
      while ((rd[CC_REQ_BIT] | rd[CC_BUSY_BIT]) !== 1'b0 &&
             n < 200) begin
         rd_reg(OFS_GLOBAL_CC, rd);
         seen_busy = seen_busy | rd[CC_BUSY_BIT];
         n++;
      end
      chk_bit(seen_busy, 1'b1);
      chk_word(rd, 64'h0000_0000_0050_0000);
      chk_num(int'(cyc - t0 > 6), 1);
      period(1, per);
      chk_num(per, 4);
      period(0, per);
      chk_num(per, 2);
      period(2, per);
      chk_num(per, 1);
      // hub power requests
      chk_bit(hub_req, 1'b0);
      core_up = 2'b10;
      #1 chk_bit(hub_req, 1'b1);
      @(negedge clk_sys);
      core_up = 2'b00;
      #1 chk_bit(hub_req, 1'b0);
      wr(OFS_HUB_PWRUP, 64'h0000_0000_0000_0001, 1'b0);
      chk_bit(hub_req, 1'b0);
      hub_op = 1'b1;
      wr(OFS_HUB_PWRUP, 64'h0000_0000_0000_0001, 1'b1);
      chk_bit(hub_req, 1'b0);
      hub_op = 1'b0;
      wr(OFS_HUB_PWRUP, 64'h0000_0000_0000_0001, 1'b1);
      chk_bit(hub_req, 1'b1);
      rd_reg(OFS_HUB_PWRUP, rd);
      chk_word(rd, 64'h0000_0000_0000_0001);
      wr(OFS_HUB_PWRUP, 64'h0000_0000_0000_0000, 1'b1);
      chk_bit(hub_req, 1'b0);
      tally_and_finish;
   end
endmodule
